// file: logic/isg_gate.v
// Output gating and fault indication for four isolated switch channels
`include "isg_map.vh"

module isg_gate #(
    parameter CH = `ISG_CH_COUNT
) (
    input  wire          sys_clk,
    input  wire          reset,
    // Variant select: high takes enables from the written register bits
    input  wire          register_enable_mode,
    // Enable pins from the host, asynchronous
    input  wire [CH-1:0] channel_enable_pin,
    input  wire          output_enable_pin,
    // Register copy written by the serial front end, same clock
    input  wire [CH-1:0] channel_switch_enable_bits,
    // Supply and protection status from the analog side, asynchronous
    input  wire          logic_supply,
    input  wire          switch_supply,
    input  wire          hard_fault,
    input  wire          over_temp_fault,
    input  wire          over_volt_fault,
    // Software remapping of the fault indicator, same clock
    input  wire          fault_indicator_override,
    input  wire          fault_indicator_force_low,
    // Channel switch outputs
    output reg  [CH-1:0] channel_switch_output,
    // Open-drain status indicators, active low
    input  wire [CH-1:0] channel_status_indicator_n_in,
    output wire [CH-1:0] channel_status_indicator_n_out,
    output reg  [CH-1:0] channel_status_indicator_n_oe,
    // Open-drain fault indicator, active low
    input  wire          fault_indicator_n_in,
    output wire          fault_indicator_n_out,
    output reg           fault_indicator_n_oe,
    // Fault state as the gating logic sees it
    output reg           fault_detected,
    // Levels read back from the shared indicator lines
    output reg           fault_line_low,
    output reg  [CH-1:0] status_line_low
);

    // Everything arriving from pins passes the synchroniser.
    // Supply and fault levels come from another domain as well, so they
    // share the same two stages; a cause may lag its pin by two clocks.
    wire [`ISG_SV_WIDTH-1:0] async_vec;
    wire [`ISG_SV_WIDTH-1:0] sync_vec;

    assign async_vec = {channel_status_indicator_n_in,
                        fault_indicator_n_in,
                        over_volt_fault,
                        over_temp_fault,
                        hard_fault,
                        switch_supply,
                        logic_supply,
                        output_enable_pin,
                        channel_enable_pin};

    isg_sync #(
        .WIDTH    (`ISG_SV_WIDTH)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (async_vec),
        .sync_out (sync_vec)
    );

    // Synchronised copies, named by use
    // Nothing below reads the raw pins directly
    wire [CH-1:0] pin_enable;
    wire          oe_level;
    wire          logic_ok;
    wire          switch_ok;
    wire          hard_flt;
    wire          temp_flt;
    wire          volt_flt;
    wire          flt_line;
    wire [CH-1:0] stat_line;

    assign pin_enable = sync_vec[CH-1:0];
    assign oe_level   = sync_vec[`ISG_SV_OE];
    assign logic_ok   = sync_vec[`ISG_SV_LOGIC_OK];
    assign switch_ok  = sync_vec[`ISG_SV_SWITCH_OK];
    assign hard_flt   = sync_vec[`ISG_SV_HARD_FLT];
    assign temp_flt   = sync_vec[`ISG_SV_OVER_TEMP];
    assign volt_flt   = sync_vec[`ISG_SV_OVER_VOLT];
    assign flt_line   = sync_vec[`ISG_SV_FLT_LINE];
    assign stat_line  = sync_vec[`ISG_SV_STAT_LO+CH-1:`ISG_SV_STAT_LO];

    // Per-channel enable source: register bit n drives channel n.
    // The register copy is already on this clock, so it is not delayed.
    function [CH-1:0] isg_pick_enable;
        input          reg_mode;
        input [CH-1:0] reg_bits;
        input [CH-1:0] pin_bits;
        begin
            isg_pick_enable = reg_mode ? reg_bits : pin_bits;
        end
    endfunction

    wire [CH-1:0] chan_enable;

    assign chan_enable = isg_pick_enable(register_enable_mode,
                                         channel_switch_enable_bits,
                                         pin_enable);

    // Fault state is purely combinational on present conditions, so it
    // drops on its own once every cause has gone; no clear is needed.
    wire [`ISG_CAUSE_W-1:0] fault_cause;
    wire                    next_fault;

    // Constraint faults count as detected even though they do not
    // force the outputs off; in the default mapping the indicator reports every cause while the logic supply is present.
    assign fault_cause = {volt_flt, temp_flt, hard_flt, ~switch_ok};
    assign next_fault  = |fault_cause;

    // Hard causes force outputs off; constraint faults are handled apart
    // Logic supply loss also lands here, so no channel outlives it
    wire force_off;

    assign force_off = ~logic_ok | ~switch_ok | hard_flt;

    // Next state of one channel. Over-temperature may hold a channel
    // that is already on but never lets an off channel start; a later
    // thermal shutdown would come in through the hard fault input.
    // Overvoltage is deliberately absent from the gating term.
    function isg_next_channel;
        input en;
        input oe;
        input blocked;
        input hot;
        input now_on;
        begin
            if (blocked || !en || !oe) begin
                isg_next_channel = `ISG_BIT_OFF;
            end else if (hot) begin
                isg_next_channel = now_on;
            end else begin
                isg_next_channel = ~`ISG_BIT_OFF;
            end
        end
    endfunction

    reg [CH-1:0] next_out;
    integer      ch_idx;

    // Each channel is judged on its own enable and its own present state
    always @* begin
        next_out = {CH{`ISG_BIT_OFF}};
        for (ch_idx = 0; ch_idx < CH; ch_idx = ch_idx + 1) begin
            next_out[ch_idx] = isg_next_channel(
                chan_enable[ch_idx], oe_level, force_off, temp_flt,
                channel_switch_output[ch_idx]);
        end
    end

    // Fault indicator drive: default mapping pulls low on a fault,
    // software may take the line over. With the logic supply gone the
    // level is undefined, so the pin is simply released.
    // The override bits are on this clock and act one clock later.
    reg next_flt_oe;

    always @* begin
        if (!logic_ok) begin
            next_flt_oe = `ISG_OE_RST;
        end else if (fault_indicator_override) begin
            next_flt_oe = fault_indicator_force_low;
        end else begin
            next_flt_oe = next_fault;
        end
    end

    // Switch outputs; the status indicators take the very same next
    // state so that a lit indicator always means an active channel
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            channel_switch_output         <= `ISG_OUT_RST;
            channel_status_indicator_n_oe <= `ISG_OUT_RST;
        end else begin
            channel_switch_output         <= next_out;
            channel_status_indicator_n_oe <= next_out;
        end
    end

    // Fault state and its indicator; neither holds a latch to clear,
    // so in the default mapping both fall on their own once the last cause has gone
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fault_indicator_n_oe <= `ISG_OE_RST;
            fault_detected       <= `ISG_OE_RST;
        end else begin
            fault_indicator_n_oe <= next_flt_oe;
            fault_detected       <= next_fault;
        end
    end

    // Shared fault line may be held low by other devices on the wire-OR,
    // so the level is reported rather than our own drive
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fault_line_low <= `ISG_OE_RST;
        end else begin
            fault_line_low <= ~flt_line;
        end
    end

    // Status lines read back the same way, one per channel
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_line_low <= `ISG_OUT_RST;
        end else begin
            status_line_low <= ~stat_line;
        end
    end

    // Open-drain pins only ever pull low; the enable carries the level,
    // which keeps the pad free of any high drive
    assign fault_indicator_n_out          = `ISG_IND_LOW;
    assign channel_status_indicator_n_out = {CH{`ISG_IND_LOW}};

endmodule

// file: pkg/isg_map.vh
// Constants for the isolated switch output gating block
`ifndef ISG_MAP_VH
`define ISG_MAP_VH

// Channel count, cause width, drive levels and reset values
`define ISG_CH_COUNT      4
`define ISG_OUT_RST       4'h0
`define ISG_IND_LOW       1'h0
`define ISG_OE_RST        1'h0
`define ISG_SYNC_RST      1'h0
`define ISG_BIT_OFF       1'h0
`define ISG_CAUSE_W       4

// Positions within the synchronised input vector
`define ISG_SV_OE         4
`define ISG_SV_LOGIC_OK   5
`define ISG_SV_SWITCH_OK  6
`define ISG_SV_HARD_FLT   7
`define ISG_SV_OVER_TEMP  8
`define ISG_SV_OVER_VOLT  9
`define ISG_SV_FLT_LINE   10
`define ISG_SV_STAT_LO    11
`define ISG_SV_WIDTH      15

`endif

// file: logic/isg_sync.v
// Two-stage synchroniser for a vector of unrelated levels
module isg_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

`include "isg_map.vh"

    reg [WIDTH-1:0] stage_one;

    // First stage feeds only the second stage
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage_one <= {WIDTH{`ISG_SYNC_RST}};
            sync_out  <= {WIDTH{`ISG_SYNC_RST}};
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

// file: tb/isg_host.sv
// Host side: pull-ups on the open-drain indicator lines
module isg_host (
    input  wire logic       fault_indicator_n_oe,
    input  wire logic [3:0] channel_status_indicator_n_oe,
    output wire logic       fault_indicator_n_in,
    output wire logic [3:0] channel_status_indicator_n_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released lines float up to the pull-up level
    assign fault_indicator_n_in = ~fault_indicator_n_oe;
    assign channel_status_indicator_n_in = ~channel_status_indicator_n_oe;
endmodule

// file: tb/isg_gate_asserts.sv
// Port-level checks for the output gating block
module isg_chk #(parameter CH = 4) (
    input wire logic          sys_clk, reset, register_enable_mode,
    input wire logic [CH-1:0] channel_enable_pin, channel_switch_enable_bits,
    input wire logic          output_enable_pin, logic_supply, switch_supply,
    input wire logic          hard_fault, over_temp_fault, over_volt_fault,
    input wire logic          fault_indicator_override,
    input wire logic          fault_indicator_force_low,
    input wire logic [CH-1:0] channel_switch_output,
    input wire logic [CH-1:0] channel_status_indicator_n_oe,
    input wire logic          fault_indicator_n_oe, fault_detected
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] age;
    wire        warm = age[2];
    wire [CH-1:0] out = channel_switch_output;
    // History reaching into reset is not judged
    always_ff @(posedge sys_clk or posedge reset)
        if (reset) age <= 3'h0;
        else if (!warm) age <= age + 3'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_GATE: assert property (
        warm |-> out == ({CH{$past(logic_supply, 3) & $past(switch_supply, 3)
        & !$past(hard_fault, 3) & $past(output_enable_pin, 3)}}
        & ($past(register_enable_mode) ? $past(channel_switch_enable_bits)
        : $past(channel_enable_pin, 3))
        & ({CH{!$past(over_temp_fault, 3)}} | $past(out)))) else $error("gating");
    AST_LED: assert property (
        channel_status_indicator_n_oe == out) else $error("status led");
    AST_LOGIC_OFF: assert property (
        warm && !$past(logic_supply, 3) |-> !out && !fault_indicator_n_oe)
        else $error("logic supply off");
    AST_SW_UV: assert property (
        warm && !$past(switch_supply, 3) |-> fault_detected && !out)
        else $error("switch undervoltage");
    AST_CLEAR: assert property (
        warm && $past(switch_supply, 3) && !$past(hard_fault, 3)
        && !$past(over_temp_fault, 3) && !$past(over_volt_fault, 3)
        |-> !fault_detected) else $error("fault clear");
    AST_FLT_PIN: assert property (
        warm && $past(logic_supply, 3) && !$past(fault_indicator_override)
        |-> fault_indicator_n_oe == fault_detected) else $error("fault pin");
    AST_REMAP: assert property (
        warm && $past(logic_supply, 3) && $past(fault_indicator_override)
        |-> fault_indicator_n_oe == $past(fault_indicator_force_low))
        else $error("fault remap");
    AST_OT_BLOCK: assert property (
        warm && $past(over_temp_fault, 3) |-> !(out & ~$past(out)))
        else $error("turn on in over-temperature");
endmodule
bind isg_gate isg_chk #(
    .CH                            (CH)
) u_chk (
    .sys_clk                       (sys_clk),
    .reset                         (reset),
    .register_enable_mode          (register_enable_mode),
    .channel_enable_pin            (channel_enable_pin),
    .channel_switch_enable_bits    (channel_switch_enable_bits),
    .output_enable_pin             (output_enable_pin),
    .logic_supply                  (logic_supply),
    .switch_supply                 (switch_supply),
    .hard_fault                    (hard_fault),
    .over_temp_fault               (over_temp_fault),
    .over_volt_fault               (over_volt_fault),
    .fault_indicator_override      (fault_indicator_override),
    .fault_indicator_force_low     (fault_indicator_force_low),
    .channel_switch_output         (channel_switch_output),
    .channel_status_indicator_n_oe (channel_status_indicator_n_oe),
    .fault_indicator_n_oe          (fault_indicator_n_oe),
    .fault_detected                (fault_detected)
);

// file: tb/tb_top.sv
// Self-checking bench for the output gating block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Every input defined from time zero
    logic sys_clk = 0, reset = 1, register_enable_mode = 0;
    logic output_enable_pin = 0, logic_supply = 0, switch_supply = 0;
    logic hard_fault = 0, over_temp_fault = 0, over_volt_fault = 0;
    logic fault_indicator_override = 0, fault_indicator_force_low = 0;
    logic [3:0] channel_enable_pin = 4'h0, channel_switch_enable_bits = 4'h0;
    wire [3:0] channel_switch_output, channel_status_indicator_n_in;
    wire [3:0] channel_status_indicator_n_out, channel_status_indicator_n_oe;
    wire [3:0] status_line_low;
    wire fault_indicator_n_in, fault_indicator_n_out, fault_indicator_n_oe;
    wire fault_detected, fault_line_low;
    // Grouped views of what each comparison looks at
    wire [9:0] seen_out = {channel_switch_output, status_line_low,
                           fault_detected, fault_line_low};
    wire [9:0] seen_rst = {channel_switch_output,
                           channel_status_indicator_n_oe,
                           fault_detected, fault_indicator_n_oe};
    wire [9:0] seen_od = {5'h00, channel_status_indicator_n_out,
                          fault_indicator_n_out};
    int bad_count = 0;
    int num_checks = 0;
    isg_gate #(
        .CH                             (4)
    ) DUT (
        .sys_clk                        (sys_clk),
        .reset                          (reset),
        .register_enable_mode           (register_enable_mode),
        .channel_enable_pin             (channel_enable_pin),
        .output_enable_pin              (output_enable_pin),
        .channel_switch_enable_bits     (channel_switch_enable_bits),
        .logic_supply                   (logic_supply),
        .switch_supply                  (switch_supply),
        .hard_fault                     (hard_fault),
        .over_temp_fault                (over_temp_fault),
        .over_volt_fault                (over_volt_fault),
        .fault_indicator_override       (fault_indicator_override),
        .fault_indicator_force_low      (fault_indicator_force_low),
        .channel_switch_output          (channel_switch_output),
        .channel_status_indicator_n_in  (channel_status_indicator_n_in),
        .channel_status_indicator_n_out (channel_status_indicator_n_out),
        .channel_status_indicator_n_oe  (channel_status_indicator_n_oe),
        .fault_indicator_n_in           (fault_indicator_n_in),
        .fault_indicator_n_out          (fault_indicator_n_out),
        .fault_indicator_n_oe           (fault_indicator_n_oe),
        .fault_detected                 (fault_detected),
        .fault_line_low                 (fault_line_low),
        .status_line_low                (status_line_low)
    );
    isg_host host (
        .fault_indicator_n_oe          (fault_indicator_n_oe),
        .channel_status_indicator_n_oe (channel_status_indicator_n_oe),
        .fault_indicator_n_in          (fault_indicator_n_in),
        .channel_status_indicator_n_in (channel_status_indicator_n_in)
    );
    initial forever #20 sys_clk = ~sys_clk;
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One comparison; a mismatch names what was looked at
    task check(input string what, input logic [9:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    // Drive, wait out both pin paths (3 edges in, 3 back), compare
    task step(input logic [16:0] v, input logic [3:0] o, input logic f, fo);
        {logic_supply, switch_supply, output_enable_pin, register_enable_mode,
         hard_fault, over_temp_fault, over_volt_fault, fault_indicator_override,
         fault_indicator_force_low, channel_enable_pin,
         channel_switch_enable_bits} = v;
        repeat (7) @(posedge sys_clk);
        #1;
        check("outputs", seen_out, {o, o, f, fo});
    endtask
    // Watchdog well past the hundred or so cycles needed
    initial begin
        #100000;
        bad_count++;
        summarize;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 reset = 0;
        step(17'h1C0A0, 4'hA, 1'b0, 1'b0);
        step(17'h180A0, 4'h0, 1'b0, 1'b0);
        step(17'h1E0A5, 4'h5, 1'b0, 1'b0);
        step(17'h1E8A5, 4'h5, 1'b1, 1'b1);
        step(17'h1E8AF, 4'h5, 1'b1, 1'b1);
        step(17'h1E0AF, 4'hF, 1'b0, 1'b0);
        step(17'h1E4AF, 4'hF, 1'b1, 1'b1);
        step(17'h1F0AF, 4'h0, 1'b1, 1'b1);
        step(17'h160AF, 4'h0, 1'b1, 1'b1);
        step(17'h162AF, 4'h0, 1'b1, 1'b0);
        step(17'h1E3AF, 4'hF, 1'b0, 1'b1);
        check("drain level", seen_od, 10'h000);
        // Mid-run reset: everything drops at once, then recovers
        reset = 1;
        @(posedge sys_clk);
        #1;
        check("in reset", seen_rst, 10'h000);
        reset = 0;
        step(17'h1E3AF, 4'hF, 1'b0, 1'b1);
        step(17'h0E0AF, 4'h0, 1'b0, 1'b0);
        summarize;
    end
endmodule
